/* File: design/ccu_chan.sv */
// one capture/compare channel: pin sync, prescaler, value register, compare latch
`timescale 1ns/1ps
`default_nettype none

module ccu_chan #(
    parameter int VAL_W = 16
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_pin,
    input wire logic i_port_latch,
    input wire logic [3:0] i_mode,
    input wire logic i_wr_low,
    input wire logic i_wr_high,
    input wire logic [7:0] i_wdata,
    input wire logic [VAL_W-1:0] i_timer,
    output logic [VAL_W-1:0] o_value,
    output logic o_flag_set,
    output logic o_special,
    output logic o_pin_out
);

    // ************************************************************
    // pin synchroniser and edges
    // ************************************************************
    logic pin_meta_q, pin_sync_q, pin_prev_q;
    logic rise, fall;
    assign rise = pin_sync_q & ~pin_prev_q;
    assign fall = ~pin_sync_q & pin_prev_q;

    always_ff @(posedge i_clk) begin
        pin_meta_q <= i_pin;
        pin_sync_q <= pin_meta_q;
        pin_prev_q <= pin_sync_q;
    end

    // ************************************************************
    // capture
    // ************************************************************
    logic is_cap, cap_evt;
    logic [ccu_pkg::PSC_W-1:0] psc_q, psc_d;
    assign is_cap = (i_mode == ccu_pkg::MODE_CAP_FALL) | (i_mode == ccu_pkg::MODE_CAP_RISE)
                  | (i_mode == ccu_pkg::MODE_CAP_RISE4) | (i_mode == ccu_pkg::MODE_CAP_RISE16);
    // prescaler survives a change between capture settings
    assign psc_d = !is_cap ? '0 : (rise ? psc_q + 1'b1 : psc_q);
    assign cap_evt = ((i_mode == ccu_pkg::MODE_CAP_FALL) & fall)
                   | ((i_mode == ccu_pkg::MODE_CAP_RISE) & rise)
                   | ((i_mode == ccu_pkg::MODE_CAP_RISE4) & rise & (psc_q[1:0] == ccu_pkg::PSC_LAST4))
                   | ((i_mode == ccu_pkg::MODE_CAP_RISE16) & rise & (psc_q == ccu_pkg::PSC_LAST16));

    // ************************************************************
    // compare
    // ************************************************************
    logic is_cmp, match, match_q, cmp_evt, drives_pin, mode_new;
    logic [3:0] mode_q;
    logic cmp_latch_q, cmp_latch_d;
    assign is_cmp = (i_mode == ccu_pkg::MODE_CMP_TOGGLE) | (i_mode == ccu_pkg::MODE_CMP_SET_HIGH)
                  | (i_mode == ccu_pkg::MODE_CMP_SET_LOW) | (i_mode == ccu_pkg::MODE_CMP_SOFT)
                  | (i_mode == ccu_pkg::MODE_CMP_SPECIAL);
    assign match = is_cmp & (o_value == i_timer);
    // only the first cycle of an equal run counts as a match
    assign cmp_evt = match & ~match_q;
    assign mode_new = (i_mode != mode_q);
    assign drives_pin = (i_mode == ccu_pkg::MODE_CMP_TOGGLE) | (i_mode == ccu_pkg::MODE_CMP_SET_HIGH)
                      | (i_mode == ccu_pkg::MODE_CMP_SET_LOW);
    assign cmp_latch_d =
        (i_mode == ccu_pkg::MODE_OFF) ? 1'b0 :
        (mode_new & (i_mode == ccu_pkg::MODE_CMP_SET_HIGH)) ? 1'b0 :
        (mode_new & (i_mode == ccu_pkg::MODE_CMP_SET_LOW)) ? 1'b1 :
        (cmp_evt & (i_mode == ccu_pkg::MODE_CMP_TOGGLE)) ? ~cmp_latch_q :
        (cmp_evt & (i_mode == ccu_pkg::MODE_CMP_SET_HIGH)) ? 1'b1 :
        (cmp_evt & (i_mode == ccu_pkg::MODE_CMP_SET_LOW)) ? 1'b0 : cmp_latch_q;

    assign o_flag_set = cap_evt | cmp_evt;
    assign o_special = cmp_evt & (i_mode == ccu_pkg::MODE_CMP_SPECIAL);

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            psc_q <= '0;
            match_q <= 1'b0;
            mode_q <= ccu_pkg::MODE_OFF;
            cmp_latch_q <= 1'b0;
            o_pin_out <= 1'b0;
        end else begin
            psc_q <= psc_d;
            match_q <= match;
            mode_q <= i_mode;
            cmp_latch_q <= cmp_latch_d;
            o_pin_out <= drives_pin ? cmp_latch_d : i_port_latch;
        end
    end

    // ************************************************************
    // value register; a capture beats a software write
    // ************************************************************
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_value <= '0;
        end else if (cap_evt) begin
            o_value <= i_timer;
        end else begin
            if (i_wr_low) begin
                o_value[7:0] <= i_wdata;
            end
            if (i_wr_high) begin
                o_value[VAL_W-1:8] <= i_wdata[VAL_W-9:0];
            end
        end
    end

endmodule

`default_nettype wire

/* File: design/ccu_pkg.sv */
// constants shared by the capture/compare unit
//
// Behaviour
// - capture loads timer count into value register
// - capture on fall, rise, 4th, 16th rise
// - mode field bits 3:0 select event
// - capture sets flag; software clears it
// - newer capture overwrites unread value
// - timer choice from second timer control bits
// - edges seen from pin level always
// - prescaler cleared when off or not capturing
// - prescaler kept across capture setting change
// - compare match does pin action and flag
// - match action: high, low, toggle, latch
// - zero control forces compare latch low
// - mode 1010 only flags, pin untouched
// - mode 1011 clears assigned timer pair
// - channel two trigger starts enabled converter
// - capture encodings 0100 to 0111
// - compare encodings 0010, 1000 to 1011
// - mode 0000 disables and resets channel
`default_nettype none

package ccu_pkg;

    // ************************************************************
    // register map (byte addresses)
    // ************************************************************
    localparam int AXI_ADDR_W = 6;
    localparam int AXI_DATA_W = 32;
    localparam logic [5:0] OFF_CH1_VALUE_LOW = 6'h00;
    localparam logic [5:0] OFF_CH1_VALUE_HIGH = 6'h04;
    localparam logic [5:0] OFF_CH1_CONTROL = 6'h08;
    localparam logic [5:0] OFF_CH2_VALUE_LOW = 6'h0C;
    localparam logic [5:0] OFF_CH2_VALUE_HIGH = 6'h10;
    localparam logic [5:0] OFF_CH2_CONTROL = 6'h14;
    localparam logic [5:0] OFF_SECOND_TIMER_CONTROL = 6'h18;
    localparam logic [5:0] OFF_FLAGS = 6'h1C;
    localparam logic [5:0] OFF_IRQ_ENABLE = 6'h20;

    // ************************************************************
    // field layout
    // ************************************************************
    localparam int CTRL_W = 6;
    localparam int MODE_MSB = 3;
    localparam int SEL_HIGH_BIT = 6;
    localparam int SEL_LOW_BIT = 3;
    localparam int CH1_BIT = 0;
    localparam int CH2_BIT = 1;
    localparam logic [5:0] CTRL_RESET = 6'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ************************************************************
    // mode field encodings
    // ************************************************************
    localparam logic [3:0] MODE_OFF = 4'h0;
    localparam logic [3:0] MODE_CMP_TOGGLE = 4'h2;
    localparam logic [3:0] MODE_CAP_FALL = 4'h4;
    localparam logic [3:0] MODE_CAP_RISE = 4'h5;
    localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
    localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
    localparam logic [3:0] MODE_CMP_SET_HIGH = 4'h8;
    localparam logic [3:0] MODE_CMP_SET_LOW = 4'h9;
    localparam logic [3:0] MODE_CMP_SOFT = 4'hA;
    localparam logic [3:0] MODE_CMP_SPECIAL = 4'hB;

    // ************************************************************
    // prescaler
    // ************************************************************
    localparam int PSC_W = 4;
    localparam logic [1:0] PSC_LAST4 = 2'h3;
    localparam logic [3:0] PSC_LAST16 = 4'hF;

endpackage

`default_nettype wire

/* File: design/ccu_top.sv */
// capture/compare unit top: axi4-lite register file and two channels
`timescale 1ns/1ps
`default_nettype none

module ccu_top #(
    parameter int VAL_W = 16
) (
    input wire logic I_SYS_CLK,
    input wire logic I_RST,
    // axi4-lite slave
    input wire logic [ccu_pkg::AXI_ADDR_W-1:0] I_AXI_AWADDR,
    input wire logic I_AXI_AWVALID,
    output logic O_AXI_AWREADY,
    input wire logic [ccu_pkg::AXI_DATA_W-1:0] I_AXI_WDATA,
    input wire logic [3:0] I_AXI_WSTRB,
    input wire logic I_AXI_WVALID,
    output logic O_AXI_WREADY,
    output logic [1:0] O_AXI_BRESP,
    output logic O_AXI_BVALID,
    input wire logic I_AXI_BREADY,
    input wire logic [ccu_pkg::AXI_ADDR_W-1:0] I_AXI_ARADDR,
    input wire logic I_AXI_ARVALID,
    output logic O_AXI_ARREADY,
    output logic [ccu_pkg::AXI_DATA_W-1:0] O_AXI_RDATA,
    output logic [1:0] O_AXI_RRESP,
    output logic O_AXI_RVALID,
    input wire logic I_AXI_RREADY,
    // module pins
    input wire logic I_CH1_PIN,
    input wire logic I_CH1_PORT_LATCH,
    output logic O_CH1_PIN_OUT,
    input wire logic I_CH2_PIN,
    input wire logic I_CH2_PORT_LATCH,
    output logic O_CH2_PIN_OUT,
    // timer pairs
    input wire logic [VAL_W-1:0] I_FIRST_TIMER_COUNT,
    input wire logic [VAL_W-1:0] I_SECOND_TIMER_COUNT,
    output logic O_FIRST_TIMER_CLEAR,
    output logic O_SECOND_TIMER_CLEAR,
    // converter
    input wire logic I_ADC_ENABLED,
    output logic O_ADC_START,
    // interrupt requests
    output logic O_CH1_IRQ,
    output logic O_CH2_IRQ
);

    // ************************************************************
    // write channel
    // ************************************************************
    logic aw_have_q, w_have_q;
    logic [ccu_pkg::AXI_ADDR_W-1:0] aw_addr_q;
    logic [ccu_pkg::AXI_DATA_W-1:0] w_data_q;
    logic w_lane0_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic wr_fire;
    logic [5:0] wr_addr;
    logic wr_mapped;

    assign O_AXI_AWREADY = ~aw_have_q & ~bvalid_q;
    assign O_AXI_WREADY = ~w_have_q & ~bvalid_q;
    assign wr_fire = aw_have_q & w_have_q & ~bvalid_q;
    assign wr_addr = {aw_addr_q[5:2], 2'b00};
    assign O_AXI_BVALID = bvalid_q;
    assign O_AXI_BRESP = bresp_q;

    // ************************************************************
    // write decode
    // ************************************************************
    logic wr_en;
    logic wr_ch1_low, wr_ch1_high, wr_ch1_ctrl;
    logic wr_ch2_low, wr_ch2_high, wr_ch2_ctrl;
    logic wr_tsel, wr_flags, wr_ien;

    assign wr_en = wr_fire & w_lane0_q;
    assign wr_ch1_low = wr_en & (wr_addr == ccu_pkg::OFF_CH1_VALUE_LOW);
    assign wr_ch1_high = wr_en & (wr_addr == ccu_pkg::OFF_CH1_VALUE_HIGH);
    assign wr_ch1_ctrl = wr_en & (wr_addr == ccu_pkg::OFF_CH1_CONTROL);
    assign wr_ch2_low = wr_en & (wr_addr == ccu_pkg::OFF_CH2_VALUE_LOW);
    assign wr_ch2_high = wr_en & (wr_addr == ccu_pkg::OFF_CH2_VALUE_HIGH);
    assign wr_ch2_ctrl = wr_en & (wr_addr == ccu_pkg::OFF_CH2_CONTROL);
    assign wr_tsel = wr_en & (wr_addr == ccu_pkg::OFF_SECOND_TIMER_CONTROL);
    assign wr_flags = wr_en & (wr_addr == ccu_pkg::OFF_FLAGS);
    assign wr_ien = wr_en & (wr_addr == ccu_pkg::OFF_IRQ_ENABLE);
    assign wr_mapped = (wr_addr == ccu_pkg::OFF_CH1_VALUE_LOW) | (wr_addr == ccu_pkg::OFF_CH1_VALUE_HIGH)
                     | (wr_addr == ccu_pkg::OFF_CH1_CONTROL) | (wr_addr == ccu_pkg::OFF_CH2_VALUE_LOW)
                     | (wr_addr == ccu_pkg::OFF_CH2_VALUE_HIGH) | (wr_addr == ccu_pkg::OFF_CH2_CONTROL)
                     | (wr_addr == ccu_pkg::OFF_SECOND_TIMER_CONTROL) | (wr_addr == ccu_pkg::OFF_FLAGS)
                     | (wr_addr == ccu_pkg::OFF_IRQ_ENABLE);

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            aw_have_q <= 1'b0;
            aw_addr_q <= '0;
        end else if (O_AXI_AWREADY & I_AXI_AWVALID) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= I_AXI_AWADDR;
        end else if (wr_fire) begin
            aw_have_q <= 1'b0;
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            w_have_q <= 1'b0;
            w_data_q <= '0;
            w_lane0_q <= 1'b0;
        end else if (O_AXI_WREADY & I_AXI_WVALID) begin
            w_have_q <= 1'b1;
            w_data_q <= I_AXI_WDATA;
            w_lane0_q <= I_AXI_WSTRB[0];
        end else if (wr_fire) begin
            w_have_q <= 1'b0;
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            bvalid_q <= 1'b0;
            bresp_q <= ccu_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_mapped ? ccu_pkg::RESP_OKAY : ccu_pkg::RESP_SLVERR;
        end else if (I_AXI_BREADY) begin
            bvalid_q <= 1'b0;
        end
    end

    // ************************************************************
    // control registers
    // ************************************************************
    logic [ccu_pkg::CTRL_W-1:0] ctrl1_q, ctrl2_q;
    logic sel_high_q, sel_low_q;
    logic [1:0] flag_q, flag_set, ien_q;
    logic [3:0] mode1, mode2;

    assign mode1 = ctrl1_q[ccu_pkg::MODE_MSB:0];
    assign mode2 = ctrl2_q[ccu_pkg::MODE_MSB:0];

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            ctrl1_q <= ccu_pkg::CTRL_RESET;
            ctrl2_q <= ccu_pkg::CTRL_RESET;
            sel_high_q <= 1'b0;
            sel_low_q <= 1'b0;
            ien_q <= '0;
        end else begin
            if (wr_ch1_ctrl) begin
                ctrl1_q <= w_data_q[ccu_pkg::CTRL_W-1:0];
            end
            if (wr_ch2_ctrl) begin
                ctrl2_q <= w_data_q[ccu_pkg::CTRL_W-1:0];
            end
            if (wr_tsel) begin
                sel_high_q <= w_data_q[ccu_pkg::SEL_HIGH_BIT];
                sel_low_q <= w_data_q[ccu_pkg::SEL_LOW_BIT];
            end
            if (wr_ien) begin
                ien_q <= w_data_q[1:0];
            end
        end
    end

    // flags are write-one-to-clear; a same-cycle set wins
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            flag_q <= '0;
        end else begin
            flag_q <= (flag_q & ~(wr_flags ? w_data_q[1:0] : 2'b00)) | flag_set;
        end
    end

    assign O_CH1_IRQ = flag_q[ccu_pkg::CH1_BIT] & ien_q[ccu_pkg::CH1_BIT];
    assign O_CH2_IRQ = flag_q[ccu_pkg::CH2_BIT] & ien_q[ccu_pkg::CH2_BIT];

    // ************************************************************
    // timer assignment
    // ************************************************************
    logic ch1_on_second, ch2_on_second;
    logic [VAL_W-1:0] timer1, timer2;

    assign ch1_on_second = sel_high_q;
    assign ch2_on_second = sel_high_q | sel_low_q;
    assign timer1 = ch1_on_second ? I_SECOND_TIMER_COUNT : I_FIRST_TIMER_COUNT;
    assign timer2 = ch2_on_second ? I_SECOND_TIMER_COUNT : I_FIRST_TIMER_COUNT;

    // ************************************************************
    // channels
    // ************************************************************
    logic [VAL_W-1:0] value1, value2;
    logic special1, special2;

    ccu_chan #(
        .VAL_W(VAL_W)
    ) u_ch1 (
        .i_clk(I_SYS_CLK),
        .i_rst(I_RST),
        .i_pin(I_CH1_PIN),
        .i_port_latch(I_CH1_PORT_LATCH),
        .i_mode(mode1),
        .i_wr_low(wr_ch1_low),
        .i_wr_high(wr_ch1_high),
        .i_wdata(w_data_q[7:0]),
        .i_timer(timer1),
        .o_value(value1),
        .o_flag_set(flag_set[ccu_pkg::CH1_BIT]),
        .o_special(special1),
        .o_pin_out(O_CH1_PIN_OUT)
    );

    ccu_chan #(
        .VAL_W(VAL_W)
    ) u_ch2 (
        .i_clk(I_SYS_CLK),
        .i_rst(I_RST),
        .i_pin(I_CH2_PIN),
        .i_port_latch(I_CH2_PORT_LATCH),
        .i_mode(mode2),
        .i_wr_low(wr_ch2_low),
        .i_wr_high(wr_ch2_high),
        .i_wdata(w_data_q[7:0]),
        .i_timer(timer2),
        .o_value(value2),
        .o_flag_set(flag_set[ccu_pkg::CH2_BIT]),
        .o_special(special2),
        .o_pin_out(O_CH2_PIN_OUT)
    );

    // ************************************************************
    // special event trigger outputs
    // ************************************************************
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            O_FIRST_TIMER_CLEAR <= 1'b0;
            O_SECOND_TIMER_CLEAR <= 1'b0;
            O_ADC_START <= 1'b0;
        end else begin
            O_FIRST_TIMER_CLEAR <= (special1 & ~ch1_on_second) | (special2 & ~ch2_on_second);
            O_SECOND_TIMER_CLEAR <= (special1 & ch1_on_second) | (special2 & ch2_on_second);
            O_ADC_START <= special2 & I_ADC_ENABLED;
        end
    end

    // ************************************************************
    // read channel
    // ************************************************************
    logic rvalid_q;
    logic [ccu_pkg::AXI_DATA_W-1:0] rdata_q;
    logic [1:0] rresp_q;
    logic rd_take;
    logic [5:0] rd_addr;
    logic [7:0] rd_byte;
    logic rd_mapped;

    assign O_AXI_ARREADY = ~rvalid_q;
    assign rd_take = I_AXI_ARVALID & ~rvalid_q;
    assign rd_addr = {I_AXI_ARADDR[5:2], 2'b00};
    assign O_AXI_RVALID = rvalid_q;
    assign O_AXI_RDATA = rdata_q;
    assign O_AXI_RRESP = rresp_q;

    assign rd_byte =
        (rd_addr == ccu_pkg::OFF_CH1_VALUE_LOW) ? value1[7:0] :
        (rd_addr == ccu_pkg::OFF_CH1_VALUE_HIGH) ? value1[VAL_W-1:8] :
        (rd_addr == ccu_pkg::OFF_CH1_CONTROL) ? {2'b00, ctrl1_q} :
        (rd_addr == ccu_pkg::OFF_CH2_VALUE_LOW) ? value2[7:0] :
        (rd_addr == ccu_pkg::OFF_CH2_VALUE_HIGH) ? value2[VAL_W-1:8] :
        (rd_addr == ccu_pkg::OFF_CH2_CONTROL) ? {2'b00, ctrl2_q} :
        (rd_addr == ccu_pkg::OFF_SECOND_TIMER_CONTROL) ? {1'b0, sel_high_q, 2'b00, sel_low_q, 3'b000} :
        (rd_addr == ccu_pkg::OFF_FLAGS) ? {6'h00, flag_q} :
        (rd_addr == ccu_pkg::OFF_IRQ_ENABLE) ? {6'h00, ien_q} : 8'h00;
    assign rd_mapped = (rd_addr == ccu_pkg::OFF_CH1_VALUE_LOW) | (rd_addr == ccu_pkg::OFF_CH1_VALUE_HIGH)
                     | (rd_addr == ccu_pkg::OFF_CH1_CONTROL) | (rd_addr == ccu_pkg::OFF_CH2_VALUE_LOW)
                     | (rd_addr == ccu_pkg::OFF_CH2_VALUE_HIGH) | (rd_addr == ccu_pkg::OFF_CH2_CONTROL)
                     | (rd_addr == ccu_pkg::OFF_SECOND_TIMER_CONTROL) | (rd_addr == ccu_pkg::OFF_FLAGS)
                     | (rd_addr == ccu_pkg::OFF_IRQ_ENABLE);

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= ccu_pkg::RESP_OKAY;
        end else if (rd_take) begin
            rvalid_q <= 1'b1;
            rdata_q <= {24'h00_0000, rd_byte};
            rresp_q <= rd_mapped ? ccu_pkg::RESP_OKAY : ccu_pkg::RESP_SLVERR;
        end else if (I_AXI_RREADY) begin
            rvalid_q <= 1'b0;
        end
    end

endmodule

`default_nettype wire

/* File: verification/ccu_checker.sv */
// port assertions for the capture/compare unit
`timescale 1ns/1ps
`default_nettype none
module ccu_checker (
    input wire logic I_SYS_CLK,
    input wire logic I_RST,
    input wire logic I_AXI_AWVALID,
    input wire logic O_AXI_AWREADY,
    input wire logic I_AXI_WVALID,
    input wire logic O_AXI_WREADY,
    input wire logic [1:0] O_AXI_BRESP,
    input wire logic O_AXI_BVALID,
    input wire logic I_AXI_BREADY,
    input wire logic [ccu_pkg::AXI_DATA_W-1:0] O_AXI_RDATA,
    input wire logic O_AXI_RVALID,
    input wire logic I_AXI_RREADY,
    input wire logic O_FIRST_TIMER_CLEAR,
    input wire logic O_SECOND_TIMER_CLEAR,
    input wire logic O_ADC_START
);
    default clocking @(posedge I_SYS_CLK); endclocking
    default disable iff (I_RST);
    sequence s_wr_take;
        I_AXI_AWVALID && O_AXI_AWREADY && I_AXI_WVALID && O_AXI_WREADY;
    endsequence
    a_write_answer: assert property (s_wr_take |=> !O_AXI_AWREADY ##1 O_AXI_BVALID)
        else $error("write not answered");
    a_bresp_hold: assert property (O_AXI_BVALID && !I_AXI_BREADY |=> O_AXI_BVALID && $stable(O_AXI_BRESP))
        else $error("write response dropped");
    a_ready_block: assert property (O_AXI_BVALID |-> !O_AXI_AWREADY && !O_AXI_WREADY)
        else $error("write taken during response");
    a_rdata_hold: assert property (O_AXI_RVALID && !I_AXI_RREADY |=> O_AXI_RVALID && $stable(O_AXI_RDATA))
        else $error("read data dropped");
    a_rdata_upper: assert property (O_AXI_RVALID |-> O_AXI_RDATA[31:8] == 24'h00_0000)
        else $error("upper read bits set");
    a_adc_with_clear: assert property (O_ADC_START |-> O_FIRST_TIMER_CLEAR || O_SECOND_TIMER_CLEAR)
        else $error("start without trigger");
    a_clear_pulse: assert property (O_FIRST_TIMER_CLEAR |=> !O_FIRST_TIMER_CLEAR [*2])
        else $error("clear pulse too long");
    a_adc_pulse: assert property (O_ADC_START |=> !O_ADC_START [*2])
        else $error("start pulse too long");
endmodule
bind ccu_top ccu_checker u_chk (.*);
`default_nettype wire

/* File: verification/ccu_timers.sv */
// timer pair model for the far side of the unit
`timescale 1ns/1ps
`default_nettype none
module ccu_timers (
    input wire logic i_clk,
    input wire logic i_zero,
    input wire logic i_run,
    input wire logic i_clr1,
    input wire logic i_clr2,
    output logic [15:0] o_cnt1,
    output logic [15:0] o_cnt2
);
    // counts core cycles only, never as an asynchronous counter
    always_ff @(posedge i_clk) begin
        if (i_zero) begin
            o_cnt1 <= 16'h0000;
            o_cnt2 <= 16'h8000;
        end else if (i_run) begin
            o_cnt1 <= i_clr1 ? 16'h0000 : o_cnt1 + 16'h0001;
            o_cnt2 <= i_clr2 ? 16'h0000 : o_cnt2 + 16'h0001;
        end
    end
endmodule
`default_nettype wire

/* File: verification/tb.sv */
// self-checking bench for the capture/compare unit
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
    logic pin1 = 1'b0, pl2 = 1'b0, zero = 1'b1, run = 1'b0, adc_en = 1'b0;
    logic [5:0] awaddr = 6'h00, araddr = 6'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'hF;
    logic [3:0] cm [4] = '{4'h9, 4'h8, 4'hA, 4'h2};
    logic [3:0] bef = 4'b0101, aft = 4'b1110;
    wire awr, wrd, bv, arr, rv, po2, clr1, clr2, adc, irq1;
    wire [1:0] rresp, bresp;
    wire [31:0] rdata;
    wire [15:0] t1, t2;
    int bad_count = 0, num_checks = 0, cycles = 0, n_adc = 0, n_clr = 0, a0, c0;
    ccu_top dut (
        .I_SYS_CLK(clk),
        .I_RST(rst),
        .I_AXI_AWADDR(awaddr),
        .I_AXI_AWVALID(awv),
        .O_AXI_AWREADY(awr),
        .I_AXI_WDATA(wdata),
        .I_AXI_WSTRB(wstrb),
        .I_AXI_WVALID(wv),
        .O_AXI_WREADY(wrd),
        .O_AXI_BRESP(bresp),
        .O_AXI_BVALID(bv),
        .I_AXI_BREADY(bready),
        .I_AXI_ARADDR(araddr),
        .I_AXI_ARVALID(arv),
        .O_AXI_ARREADY(arr),
        .O_AXI_RDATA(rdata),
        .O_AXI_RRESP(rresp),
        .O_AXI_RVALID(rv),
        .I_AXI_RREADY(rready),
        .I_CH1_PIN(pin1),
        .I_CH1_PORT_LATCH(1'b0),
        .O_CH1_PIN_OUT(),
        .I_CH2_PIN(1'b0),
        .I_CH2_PORT_LATCH(pl2),
        .O_CH2_PIN_OUT(po2),
        .I_FIRST_TIMER_COUNT(t1),
        .I_SECOND_TIMER_COUNT(t2),
        .O_FIRST_TIMER_CLEAR(clr1),
        .O_SECOND_TIMER_CLEAR(clr2),
        .I_ADC_ENABLED(adc_en),
        .O_ADC_START(adc),
        .O_CH1_IRQ(irq1),
        .O_CH2_IRQ()
    );
    ccu_timers u_tmr (.i_clk(clk), .i_zero(zero), .i_run(run), .i_clr1(clr1), .i_clr2(clr2), .o_cnt1(t1), .o_cnt2(t2));
    initial begin
        forever #5 clk = ~clk;
    end
    // ****
    // tasks
    // ****
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wrd) wv <= 1'b0;
        end while (!bv);
        bready <= 1'b0;
        chk(bresp, (a > ccu_pkg::OFF_IRQ_ENABLE) ? ccu_pkg::RESP_SLVERR : ccu_pkg::RESP_OKAY);
    endtask
    task automatic rchk(input logic [5:0] a, input logic [31:0] e);
        @(posedge clk);
        araddr <= a;
        arv <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
        end while (!rv);
        rready <= 1'b0;
        chk(rdata, e);
        chk(rresp, (a > ccu_pkg::OFF_IRQ_ENABLE) ? ccu_pkg::RESP_SLVERR : ccu_pkg::RESP_OKAY);
    endtask
    task automatic pulse();
        @(posedge clk);
        pin1 <= 1'b1;
        repeat (6) @(posedge clk);
        pin1 <= 1'b0;
        repeat (6) @(posedge clk);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        n_adc += int'(adc);
        n_clr += int'(clr1);
        if (cycles == 20000) begin
            bad_count++;
            summarize();
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rchk(ccu_pkg::OFF_CH1_CONTROL, 32'h0000_0000);
        wr(ccu_pkg::OFF_CH1_CONTROL, 32'h0000_00FF);
        rchk(ccu_pkg::OFF_CH1_CONTROL, 32'h0000_003F);
        wr(ccu_pkg::OFF_SECOND_TIMER_CONTROL, 32'h0000_00FF);
        rchk(ccu_pkg::OFF_SECOND_TIMER_CONTROL, 32'h0000_0048);
        wr(6'h24, 32'h0000_00FF);
        rchk(6'h24, 32'h0000_0000);
        $display("test registers done");
        zero <= 1'b0;
        run <= 1'b1;
        repeat (300) @(posedge clk);
        run <= 1'b0;
        wr(ccu_pkg::OFF_CH1_CONTROL, 32'(ccu_pkg::MODE_CAP_RISE));
        pulse();
        wr(ccu_pkg::OFF_SECOND_TIMER_CONTROL, 32'h0000_0000);
        pulse();
        rchk(ccu_pkg::OFF_CH1_VALUE_LOW, 32'(t1[7:0]));
        rchk(ccu_pkg::OFF_CH1_VALUE_HIGH, 32'(t1[15:8]));
        wr(ccu_pkg::OFF_SECOND_TIMER_CONTROL, 32'h0000_0040);
        pulse();
        rchk(ccu_pkg::OFF_CH1_VALUE_HIGH, 32'(t2[15:8]));
        rchk(ccu_pkg::OFF_FLAGS, 32'h0000_0001);
        wr(ccu_pkg::OFF_IRQ_ENABLE, 32'h0000_0001);
        chk(irq1, 1'b1);
        wr(ccu_pkg::OFF_FLAGS, 32'h0000_0001);
        chk(irq1, 1'b0);
        $display("test capture done");
        for (int i = 0; i < 4; i++) begin
            wr(ccu_pkg::OFF_CH1_CONTROL, 32'h0000_0000);
            wr(ccu_pkg::OFF_CH1_CONTROL, 32'(ccu_pkg::MODE_CAP_FALL + 4'(i)));
            wr(ccu_pkg::OFF_FLAGS, 32'h0000_0001);
            repeat ((i < 2) ? 0 : (i == 2 ? 3 : 15)) pulse();
            rchk(ccu_pkg::OFF_FLAGS, 32'h0000_0000);
            pulse();
            rchk(ccu_pkg::OFF_FLAGS, 32'h0000_0001);
        end
        $display("test prescaler done");
        pl2 <= 1'b1;
        run <= 1'b1;
        wr(ccu_pkg::OFF_SECOND_TIMER_CONTROL, 32'h0000_0000);
        wr(ccu_pkg::OFF_CH2_VALUE_LOW, 32'h0000_0040);
        for (int i = 0; i < 4; i++) begin
            zero <= 1'b1;
            if (i == 2) wr(ccu_pkg::OFF_CH2_CONTROL, 32'h0000_0000);
            wr(ccu_pkg::OFF_CH2_CONTROL, 32'(cm[i]));
            wr(ccu_pkg::OFF_FLAGS, 32'h0000_0003);
            chk(po2, bef[i]);
            zero <= 1'b0;
            repeat (100) @(posedge clk);
            chk(po2, aft[i]);
            rchk(ccu_pkg::OFF_FLAGS, 32'h0000_0002);
        end
        for (int e = 1; e >= 0; e--) begin
            zero <= 1'b1;
            adc_en <= e[0];
            wr(ccu_pkg::OFF_CH2_CONTROL, 32'(ccu_pkg::MODE_CMP_SPECIAL));
            a0 = n_adc;
            c0 = n_clr;
            zero <= 1'b0;
            repeat (300) @(posedge clk);
            // match at 0x40, restart two cycles later: a period of 66 cycles
            chk(n_clr - c0, 32'd4);
            chk(n_adc - a0, e ? 32'd4 : 32'd0);
        end
        $display("test compare done");
        summarize();
    end
endmodule
`default_nettype wire
